// ===== shared/dual_timer_regs.svh
// Purpose: Constants for the dual half timer
// Assumes: 100 MHz system clock
// Notes:   Field positions, codes and reset values
`ifndef DUAL_TIMER_REGS_SVH
`define DUAL_TIMER_REGS_SVH
`define CFG_SEL_W          3
`define CFG_32_PERIODIC    3'h0
`define CFG_32_CLOCK       3'h1
`define CFG_16_SPLIT       3'h4
`define MODE_FIELD_W       2
`define MODE_ONESHOT       2'h1
`define MODE_PERIODIC      2'h2
`define HALF_RESET         16'hffff
`define PRESCALE_RESET     8'h00
`define IRQ_BITS           4
`define IRQ_LOW_TIMEOUT    0
`endif

// ===== shared/dual_timer_pkg.sv
// Purpose: Types for the dual half timer
// Assumes: Constants come from dual_timer_regs.svh
// Notes:   Control bits travel as one packed struct
`include "dual_timer_regs.svh"
package dual_timer_pkg;
  typedef struct packed {
    logic runEnable;
    logic trigOutEnable;
    logic stallEnable;
  } half_ctl_t;
  typedef struct packed {
    logic                     valid;
    logic [`MODE_FIELD_W-1:0] modeField;
  } mode_wr_t;
endpackage : dual_timer_pkg

// ===== rtl/dual_half_timer.sv
// Purpose: Two 16-bit halves joined as one 32-bit one-shot or periodic down-counter
// Assumes: Control bits arrive as one packed struct port, synchronous to clk
// Notes:   Only the 32-bit one-shot/periodic behaviour counts; other modes hold
//
// Functional notes
// - Two 16-bit halves, joinable into 32 bits
// - Internal-only instance has no capture pins
// - 32-bit configuration acts as one timer
// - Reset leaves block idle, controls cleared
// - Reset loads counters and loads with ones
// - Reset clears both prescale registers
// - Select 0 periodic, 1 clock, joined views
// - Wide load write fills both halves
// - Count read gives high:low halves
// - Joined halves form one down-counter
// - Only low mode field picks one-shot/periodic
// - Low enable starts count from preload
// - Zero count reloads next cycle
// - One-shot stops and clears own enable
// - Zero sets sticky raw time-out flag
// - Unmasked raw flag sets masked flag
// - Trigger pulses one cycle, in the cycle after zero
// - Live load write taken next cycle
// - Stall freezes count while asserted
// - Masked flag raises interrupt request
`include "dual_timer_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module dual_half_timer
  import dual_timer_pkg::*;
#(
  parameter int  HALF_W       = 16,
  parameter int  PRESCALE_W   = 8,
  parameter bit  HAS_CAPTURE  = 1'b1
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Configuration select write
  input  wire logic                   cfgWrite,
  input  wire logic [`CFG_SEL_W-1:0]  cfgData,
  // Mode register writes
  input  wire mode_wr_t               lowModeWr,
  input  wire mode_wr_t               highModeWr,
  // Control register write
  input  wire logic                   ctlWrite,
  input  wire half_ctl_t              ctlData,
  // Interval load write
  input  wire logic                   loadWrite,
  input  wire logic [2*HALF_W-1:0]    loadData,
  // Prescale writes
  input  wire logic                   preWriteLow,
  input  wire logic                   preWriteHigh,
  input  wire logic [PRESCALE_W-1:0]  preData,
  // Interrupt mask and clear
  input  wire logic                   maskWrite,
  input  wire logic [`IRQ_BITS-1:0]   maskData,
  input  wire logic                   clearWrite,
  input  wire logic [`IRQ_BITS-1:0]   clearData,
  // Stall from debug
  input  wire logic                   stall,
  // Capture/compare pin inputs
  input  wire logic [1:0]             capturePin,
  // Status and views
  output logic [`CFG_SEL_W-1:0]       cfgSel,
  output half_ctl_t                   ctlState,
  output logic [2*HALF_W-1:0]         countView,
  output logic [2*HALF_W-1:0]         loadView,
  output logic [PRESCALE_W-1:0]       lowPrescale,
  output logic [PRESCALE_W-1:0]       highPrescale,
  output logic [`IRQ_BITS-1:0]        rawStatus,
  output logic [`IRQ_BITS-1:0]        maskedStatus,
  output logic [`IRQ_BITS-1:0]        irqMask,
  // Events
  output logic                        trigOut,
  output logic                        irqReq
);

  logic                        rstSync1_r;
  logic                        rstSync2_r;
  logic                        rstN;
  logic [`CFG_SEL_W-1:0]       cfg_r;
  logic [`MODE_FIELD_W-1:0]    lowMode_r;
  logic [`MODE_FIELD_W-1:0]    highMode_r;
  half_ctl_t                   ctl_r;
  logic [HALF_W-1:0]           lowCnt_r;
  logic [HALF_W-1:0]           highCnt_r;
  logic [HALF_W-1:0]           lowLoad_r;
  logic [HALF_W-1:0]           highLoad_r;
  logic [PRESCALE_W-1:0]       lowPre_r;
  logic [PRESCALE_W-1:0]       highPre_r;
  logic [`IRQ_BITS-1:0]        raw_r;
  logic [`IRQ_BITS-1:0]        mask_r;
  logic                        trig_r;
  logic                        pendLoad_r;
  logic                        wide;
  logic                        running;
  logic                        frozen;
  logic                        atZero;
  logic                        zeroHit;
  logic [2*HALF_W-1:0]         count;
  logic [2*HALF_W-1:0]         countNxt;
  logic [`IRQ_BITS-1:0]        rawSet;
  logic                        capUsed;
  logic                        clrLow;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1_r <= 1'b0;
      rstSync2_r <= 1'b0;
    end else begin
      rstSync1_r <= 1'b1;
      rstSync2_r <= rstSync1_r;
    end
  end
  assign rstN = rstSync2_r;

  // Capture pins exist only on external instances
  assign capUsed = HAS_CAPTURE ? |capturePin : 1'b0;

  assign wide    = (cfg_r == `CFG_32_PERIODIC);
  assign count   = {highCnt_r, lowCnt_r};
  assign running = wide && ctl_r.runEnable;
  assign frozen  = ctl_r.stallEnable && stall;
  assign atZero  = (count == '0);
  assign zeroHit = running && !frozen && !pendLoad_r && atZero;

  // Configuration and mode registers
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cfg_r      <= `CFG_32_PERIODIC;
      lowMode_r  <= '0;
      highMode_r <= '0;
      mask_r     <= '0;
    end else begin
      if (cfgWrite)
        cfg_r <= cfgData;
      if (lowModeWr.valid)
        lowMode_r <= lowModeWr.modeField;
      if (highModeWr.valid)
        highMode_r <= highModeWr.modeField;
      if (maskWrite)
        mask_r <= maskData;
    end
  end

  // Control: one-shot clears its own enable at zero
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ctl_r <= '0;
    end else if (zeroHit && lowMode_r != `MODE_PERIODIC) begin
      ctl_r.runEnable     <= 1'b0;
      ctl_r.trigOutEnable <= ctlWrite ? ctlData.trigOutEnable : ctl_r.trigOutEnable;
      ctl_r.stallEnable   <= ctlWrite ? ctlData.stallEnable : ctl_r.stallEnable;
    end else if (ctlWrite) begin
      ctl_r <= ctlData;
    end
  end

  // Interval loads; every write is copied into the counter next cycle
  // Idle writes preload the start value, live writes restart from it
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      lowLoad_r  <= `HALF_RESET;
      highLoad_r <= `HALF_RESET;
      pendLoad_r <= 1'b0;
    end else begin
      pendLoad_r <= loadWrite;
      if (loadWrite) begin
        lowLoad_r <= loadData[HALF_W-1:0];
        if (wide)
          highLoad_r <= loadData[2*HALF_W-1:HALF_W];
      end
    end
  end

  // Prescalers, unused in 32-bit operation
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      lowPre_r  <= `PRESCALE_RESET;
      highPre_r <= `PRESCALE_RESET;
    end else begin
      if (preWriteLow)
        lowPre_r <= preData;
      if (preWriteHigh)
        highPre_r <= preData;
    end
  end

  // Counter next value
  always_comb begin
    countNxt = count;
    if (pendLoad_r)
      countNxt = {highLoad_r, lowLoad_r};
    else if (running && !frozen) begin
      if (atZero)
        countNxt = {highLoad_r, lowLoad_r};
      else
        countNxt = count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      lowCnt_r  <= `HALF_RESET;
      highCnt_r <= `HALF_RESET;
    end else begin
      lowCnt_r  <= countNxt[HALF_W-1:0];
      highCnt_r <= countNxt[2*HALF_W-1:HALF_W];
    end
  end

  // Sticky flags; a new event beats a clear in the same cycle
  always_comb begin
    rawSet = '0;
    rawSet[`IRQ_LOW_TIMEOUT] = zeroHit;
  end

  assign clrLow = clearWrite && clearData[`IRQ_LOW_TIMEOUT];

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      raw_r <= '0;
    end else begin
      raw_r <= (raw_r & ~(clearWrite ? clearData : '0)) | rawSet;
    end
  end

  // Trigger pulse in the cycle after zero
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN)
      trig_r <= 1'b0;
    else
      trig_r <= zeroHit && ctl_r.trigOutEnable;
  end

  assign cfgSel       = cfg_r;
  assign ctlState     = ctl_r;
  assign countView    = count;
  assign loadView     = {highLoad_r, lowLoad_r};
  assign lowPrescale  = lowPre_r;
  assign highPrescale = highPre_r;
  assign rawStatus    = raw_r;
  assign irqMask      = mask_r;
  assign maskedStatus = raw_r & mask_r;
  assign irqReq       = |(raw_r & mask_r) && (capUsed || 1'b1);
  assign trigOut      = trig_r;

  // Assertions
  sequence zeroEvt_s;
    zeroHit;
  endsequence

  sequence reloaded_s;
    ##1 (count == $past(loadView));
  endsequence

  reload_next_a: assert property (@(posedge clk) disable iff (!rstN)
    zeroEvt_s |-> reloaded_s) else $error("No reload after zero");

  oneshot_stop_a: assert property (@(posedge clk) disable iff (!rstN)
    zeroHit && lowMode_r != `MODE_PERIODIC && !ctlWrite |=> !ctl_r.runEnable)
    else $error("One-shot enable not cleared");

  periodic_keep_a: assert property (@(posedge clk) disable iff (!rstN)
    zeroHit && lowMode_r == `MODE_PERIODIC && !ctlWrite |=> ctl_r.runEnable)
    else $error("Periodic enable dropped");

  raw_sticky_a: assert property (@(posedge clk) disable iff (!rstN)
    zeroEvt_s |=> raw_r[`IRQ_LOW_TIMEOUT] ##1 (raw_r[`IRQ_LOW_TIMEOUT] || $past(clrLow)))
    else $error("Raw flag not held");

  masked_irq_a: assert property (@(posedge clk) disable iff (!rstN)
    raw_r[`IRQ_LOW_TIMEOUT] && mask_r[`IRQ_LOW_TIMEOUT] |-> maskedStatus[`IRQ_LOW_TIMEOUT] && irqReq)
    else $error("Masked flag or request missing");

  trig_pulse_a: assert property (@(posedge clk) disable iff (!rstN)
    trigOut |=> !trigOut) else $error("Trigger longer than one cycle");

  trig_cause_a: assert property (@(posedge clk) disable iff (!rstN)
    zeroHit && ctl_r.trigOutEnable |=> trigOut) else $error("Trigger missing");

  live_load_a: assert property (@(posedge clk) disable iff (!rstN)
    loadWrite && running && wide |-> ##2 (count == $past(loadData, 2)))
    else $error("Live load not taken");

  stall_hold_a: assert property (@(posedge clk) disable iff (!rstN)
    frozen && !pendLoad_r |=> $stable(count)) else $error("Count moved in stall");

  count_down_a: assert property (@(posedge clk) disable iff (!rstN)
    running && !frozen && !pendLoad_r && !atZero |=> count == $past(count) - 32'h1)
    else $error("Count did not decrement");

  clear_a: assert property (@(posedge clk) disable iff (!rstN)
    clearWrite && clearData[`IRQ_LOW_TIMEOUT] && !zeroHit |=> !raw_r[`IRQ_LOW_TIMEOUT])
    else $error("Clear ignored");

  clear_keep_a: assert property (@(posedge clk) disable iff (!rstN)
    clearWrite && !clearData[`IRQ_LOW_TIMEOUT] && raw_r[`IRQ_LOW_TIMEOUT] |=> raw_r[`IRQ_LOW_TIMEOUT])
    else $error("Zero clear bit dropped flag");

  split_load_a: assert property (@(posedge clk) disable iff (!rstN)
    loadWrite && wide |=> loadView == $past(loadData))
    else $error("Wide load not split");

  split_idle_a: assert property (@(posedge clk) disable iff (!rstN)
    !wide && !pendLoad_r |=> $stable(count))
    else $error("Joined counter ran outside wide mode");

  high_mode_a: assert property (@(posedge clk) disable iff (!rstN)
    highModeWr.valid && !lowModeWr.valid |=> $stable(lowMode_r))
    else $error("High mode write changed low mode");

  start_run_a: assert property (@(posedge clk) disable iff (!rstN)
    $rose(ctl_r.runEnable) && wide && !frozen && !pendLoad_r && !atZero |=> count == $past(count) - 32'h1)
    else $error("Count did not start");

  masked_off_a: assert property (@(posedge clk) disable iff (!rstN)
    !mask_r[`IRQ_LOW_TIMEOUT] |-> !maskedStatus[`IRQ_LOW_TIMEOUT])
    else $error("Masked flag set while masked off");

  trig_quiet_a: assert property (@(posedge clk) disable iff (!rstN)
    !ctl_r.trigOutEnable |=> !trigOut)
    else $error("Trigger while disabled");

  // Stall released: counting picks up at once
  sequence resume_s;
    frozen ##1 (!frozen && running && !pendLoad_r && !atZero);
  endsequence

  stall_resume_a: assert property (@(posedge clk) disable iff (!rstN)
    resume_s |=> count == $past(count) - 32'h1)
    else $error("Count did not resume");

  reset_count_a: assert property (@(posedge clk) disable iff (!rstN)
    $rose(rstN) |-> count == {2{`HALF_RESET}} && loadView == {2{`HALF_RESET}})
    else $error("Count or load not all ones");

  reset_idle_a: assert property (@(posedge clk) disable iff (!rstN)
    $rose(rstN) |-> ctl_r == '0 && raw_r == '0 && !trigOut)
    else $error("Block not idle after reset");

  reset_pre_a: assert property (@(posedge clk) disable iff (!rstN)
    $rose(rstN) |-> lowPre_r == `PRESCALE_RESET && highPre_r == `PRESCALE_RESET)
    else $error("Prescale not cleared");

endmodule : dual_half_timer
`default_nettype wire

// ===== dv/dual_half_timer_bench.sv
// Purpose: Self-checking bench for the joined 32-bit one-shot/periodic timer
// Assumes: Write strobes last one cycle and are sampled on the rising edge
// Notes:   Inputs change on the falling edge; assertions live in the design
`include "dual_timer_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module dual_half_timer_bench;
  import dual_timer_pkg::*;
  typedef struct packed {
    logic [1:0]  lowMode;
    logic [1:0]  highMode;
    logic [31:0] load;
    logic        trigEn;
    logic        maskOn;
    logic        periodic;
  } row_t;
  logic        clk, rst_n, cfgWrite, ctlWrite, loadWrite, preWriteLow, preWriteHigh;
  logic        maskWrite, clearWrite, stall, trigOut, irqReq;
  logic [2:0]  cfgData, cfgSel;
  logic [3:0]  maskData, clearData, rawStatus, maskedStatus, irqMask;
  logic [7:0]  preData, lowPrescale, highPrescale;
  logic [31:0] loadData, countView, loadView;
  mode_wr_t    lowModeWr, highModeWr;
  half_ctl_t   ctlData, ctlState;
  int          bad_count, checks_done, n;
  row_t        r;
  row_t        rows [5] = '{'{2'h1, 2'h2, 32'h5, 1'b1, 1'b1, 1'b0}, '{2'h2, 2'h1, 32'h3, 1'b1, 1'b0, 1'b1},
                            '{2'h0, 2'h2, 32'h2, 1'b0, 1'b1, 1'b0}, '{2'h3, 2'h2, 32'h4, 1'b1, 1'b0, 1'b0},
                            '{2'h2, 2'h2, 32'h1, 1'b0, 1'b1, 1'b1}};

  dual_half_timer dut_u (.clk(clk), .rst_n(rst_n), .cfgWrite(cfgWrite), .cfgData(cfgData),
    .lowModeWr(lowModeWr), .highModeWr(highModeWr), .ctlWrite(ctlWrite), .ctlData(ctlData),
    .loadWrite(loadWrite), .loadData(loadData), .preWriteLow(preWriteLow), .preWriteHigh(preWriteHigh),
    .preData(preData), .maskWrite(maskWrite), .maskData(maskData), .clearWrite(clearWrite),
    .clearData(clearData), .stall(stall), .capturePin(2'h0), .cfgSel(cfgSel), .ctlState(ctlState),
    .countView(countView), .loadView(loadView), .lowPrescale(lowPrescale), .highPrescale(highPrescale),
    .rawStatus(rawStatus), .maskedStatus(maskedStatus), .irqMask(irqMask), .trigOut(trigOut),
    .irqReq(irqReq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : chk

  task automatic print_verdict;
    if (bad_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // One write cycle, then all strobes drop
  task automatic step;
    @(posedge clk);
    @(negedge clk);
    {cfgWrite, ctlWrite, loadWrite, preWriteLow, preWriteHigh, maskWrite, clearWrite} = 7'h0;
    lowModeWr.valid  = 1'b0;
    highModeWr.valid = 1'b0;
  endtask : step

  task automatic do_reset(input int cycles);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (cycles) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    chk("count", 32'hffff_ffff, countView);
    chk("load", 32'hffff_ffff, loadView);
    chk("prescale", 32'h0, {lowPrescale, highPrescale});
    chk("ctl", 32'h0, 32'({cfgSel, ctlState, rawStatus, irqMask, trigOut}));
  endtask : do_reset

  initial begin
    {cfgWrite, ctlWrite, loadWrite, preWriteLow, preWriteHigh, maskWrite, clearWrite, stall} = 8'h0;
    {cfgData, maskData, clearData, preData, loadData} = 51'h0;
    lowModeWr  = '0;
    highModeWr = '0;
    ctlData    = '0;
    rst_n      = 1'b0;
    bad_count  = 0;
    checks_done = 0;
    do_reset(10);
    foreach (rows[i]) begin
      r = rows[i];
      lowModeWr  = '{1'b1, r.lowMode};
      highModeWr = '{1'b1, r.highMode};
      maskWrite  = 1'b1;
      maskData   = {3'h0, r.maskOn};
      loadWrite  = 1'b1;
      loadData   = r.load;
      step();
      chk("irqMask", 32'(r.maskOn), 32'(irqMask));
      ctlWrite = 1'b1;
      ctlData  = '{1'b1, r.trigEn, 1'b0};
      step();
      n = 0;
      while (rawStatus[0] !== 1'b1 && n < 100) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk("zeroTime", r.load + 1, n);
      if (n >= 100) print_verdict();
      chk("reload", r.load, countView);
      chk("trig", 32'(r.trigEn), 32'(trigOut));
      chk("run", 32'(r.periodic), 32'(ctlState.runEnable));
      chk("masked", 32'({2{r.maskOn}}), 32'({maskedStatus[0], irqReq}));
      @(posedge clk);
      #1;
      chk("trigEnd", 32'h0, 32'(trigOut));
      chk("after", r.periodic ? r.load - 1 : r.load, countView);
      @(negedge clk);
      ctlWrite   = 1'b1;
      ctlData    = '0;
      clearWrite = 1'b1;
      clearData  = 4'he;
      step();
      chk("rawKeep", 32'h1, 32'(rawStatus[0]));
      clearWrite = 1'b1;
      clearData  = 4'h1;
      step();
      chk("rawClr", 32'h0, 32'({rawStatus[0], maskedStatus[0], irqReq}));
    end
    loadWrite   = 1'b1;
    loadData    = 32'h1234_5678;
    preWriteLow = 1'b1;
    preData     = 8'ha5;
    step();
    chk("split", 32'h1234_5678, loadView);
    preWriteHigh = 1'b1;
    preData      = 8'h3c;
    step();
    chk("pre", 32'ha53c, {lowPrescale, highPrescale});
    // Borrow across the halves, then a live reload
    loadWrite = 1'b1;
    loadData  = 32'h0001_0000;
    step();
    ctlWrite = 1'b1;
    ctlData  = '{1'b1, 1'b0, 1'b1};
    step();
    @(posedge clk);
    #1;
    chk("borrow", 32'h0000_ffff, countView);
    @(negedge clk);
    loadWrite = 1'b1;
    loadData  = 32'h20;
    step();
    @(posedge clk);
    #1;
    chk("live", 32'h20, countView);
    @(posedge clk);
    #1;
    chk("liveNext", 32'h1f, countView);
    @(negedge clk);
    stall = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("stall", 32'h1f, countView);
    @(negedge clk);
    stall = 1'b0;
    @(posedge clk);
    #1;
    chk("resume", 32'h1e, countView);
    @(negedge clk);
    cfgWrite = 1'b1;
    cfgData  = `CFG_16_SPLIT;
    step();
    repeat (3) @(posedge clk);
    #1;
    chk("cfgSel", 32'h4, 32'(cfgSel));
    chk("cfgHalt", 32'h1d, countView);
    do_reset(2);
    print_verdict();
  end
endmodule : dual_half_timer_bench
`default_nettype wire
